// ---- phyec_cfg.svh ----
// Offsets, field positions, reset values and timing figures of the counter and PCS block
`ifndef PHYEC_CFG_SVH
`define PHYEC_CFG_SVH

`define PHYEC_OFS_FALSE_CARRIER 5'h14
`define PHYEC_OFS_RX_ERROR 5'h15
`define PHYEC_OFS_CODING_CFG 5'h16

`define PHYEC_CNT_MSB 7
`define PHYEC_CNT_MAX 8'hff
`define PHYEC_CNT_HALF 8'h7f

`define PHYEC_BIT_FREE_CLK 11
`define PHYEC_BIT_TRUE_QUIET 10
`define PHYEC_BIT_SD_FORCE 9
`define PHYEC_BIT_SIGNAL_DETECT_OPTION 8
`define PHYEC_BIT_DESCRAMBLER_TIMEOUT_SELECT 7
`define PHYEC_BIT_FORCE_100_OK 5
`define PHYEC_BIT_NRZI_BYPASS 2

`define PHYEC_CFG_RESET 16'h0100
`define PHYEC_CFG_WR_MASK 16'h0fa4

`define PHYEC_CLK_PERIOD_NS 20
`define PHYEC_DESC_SHORT_NS 722000
`define PHYEC_DESC_LONG_NS 2000000

`endif

// ---- phyec_pkg.sv ----
// Types shared by the counter and PCS configuration block
package phyec_pkg;
	typedef enum logic [1:0] {
		PHYEC_LINK_DOWN = 2'b01,
		PHYEC_LINK_UP = 2'b10
	} phyec_link_state_t;

	typedef logic [16:0] phyec_timer_t;
endpackage

// ---- phyec_regs.sv ----
// Error counters and 100 Mb/s coding sublayer configuration registers
`timescale 1ns/1ps
`include "phyec_cfg.svh"

// Overview of operation
// R1: False carrier events counted in 8 bits
// R2: False carrier count sticks at FFh
// R3: Counts reset zero, cleared by read
// R4: Unused high bits read zero, ignore writes
// R5: Count carrier with invalid symbol received
// R6: At most one count per carrier
// R7: No count when carrier saw collision
// R8: Receive error count sticks at maximum
// R9: Bit 10 selects true quiet transmit
// R10: Bit 9 forces signal detect asserted
// R11: Option one: loss of lock ignored
// R12: Option zero: lost lock drops link
// R13: Bit 7 picks 722us or 2ms timeout
// R14: Bit 5 forces good 100 link
// R15: Bit 2 bypasses NRZI coding
// R16: Manager writes zero to reserved bits; the model clears only bits 12, 6, 4, 3, 1 and 0, and the bench sets bits 15:13
// R17: Reset value: only option bit set
// R18: Half-full events go to interrupt logic
// R19: Half-full event once per MSB rise
module phyec_regs
	import phyec_pkg::*;
#(
	parameter int unsigned DESC_SHORT_CYCLES = `PHYEC_DESC_SHORT_NS / `PHYEC_CLK_PERIOD_NS,
	parameter int unsigned DESC_LONG_CYCLES = `PHYEC_DESC_LONG_NS / `PHYEC_CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [4:0] mgmt_addr,
	input wire logic mgmt_rd,
	input wire logic mgmt_wr,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	input wire logic false_carrier_event,
	input wire logic rx_carrier,
	input wire logic rx_symbol_error,
	input wire logic rx_collision,
	input wire logic signal_level_valid,
	input wire logic descrambler_sync,
	output logic signal_detect,
	output logic descrambler_locked,
	output logic link_100_ok,
	output logic true_quiet_enable,
	output logic nrzi_bypass,
	output logic free_rx_clock,
	output logic false_carrier_half_full_event,
	output logic receive_error_half_full_event
);
	logic [15:0] rdata_q;
	logic [15:0] cfg_q;
	logic [7:0] false_carrier_count_q;
	logic [7:0] receive_error_count_q;
	logic carrier_q;
	logic err_seen_q;
	logic coll_seen_q;
	logic lock_q;
	phyec_timer_t timer_q;
	phyec_timer_t timeout_limit;
	phyec_link_state_t link_q;
	logic fc_hf_q;
	logic re_hf_q;
	logic rd_fc;
	logic rd_re;
	logic wr_cfg;
	logic carrier_end;
	logic re_inc;
	logic signal_detect_force;
	logic signal_detect_option;
	logic force_good_link;

	// Reads and writes are single-cycle strobes from the management frame engine
	assign rd_fc = mgmt_rd && (mgmt_addr == `PHYEC_OFS_FALSE_CARRIER);
	assign rd_re = mgmt_rd && (mgmt_addr == `PHYEC_OFS_RX_ERROR);
	assign wr_cfg = mgmt_wr && (mgmt_addr == `PHYEC_OFS_CODING_CFG);

	assign signal_detect_force = cfg_q[`PHYEC_BIT_SD_FORCE];
	assign signal_detect_option = cfg_q[`PHYEC_BIT_SIGNAL_DETECT_OPTION];
	assign force_good_link = cfg_q[`PHYEC_BIT_FORCE_100_OK];
	assign true_quiet_enable = cfg_q[`PHYEC_BIT_TRUE_QUIET]; // see R9
	assign nrzi_bypass = cfg_q[`PHYEC_BIT_NRZI_BYPASS]; // see R15
	assign free_rx_clock = cfg_q[`PHYEC_BIT_FREE_CLK];
	assign signal_detect = signal_level_valid || signal_detect_force; // see R10
	assign descrambler_locked = lock_q;
	assign link_100_ok = force_good_link || (link_q == PHYEC_LINK_UP); // see R14
	assign mgmt_rdata = rdata_q;
	assign false_carrier_half_full_event = fc_hf_q; // see R18
	assign receive_error_half_full_event = re_hf_q; // see R18

	// Reserved bits are masked so a careless write cannot reach them
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_q <= `PHYEC_CFG_RESET; // see R17
		end else if (clk_en && wr_cfg) begin
			cfg_q <= mgmt_wdata & `PHYEC_CFG_WR_MASK; // see R4
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_q <= 16'h0000;
		end else if (clk_en && mgmt_rd) begin
			if (mgmt_addr == `PHYEC_OFS_FALSE_CARRIER) begin
				rdata_q <= {8'h00, false_carrier_count_q}; // see R4
			end else if (mgmt_addr == `PHYEC_OFS_RX_ERROR) begin
				rdata_q <= {8'h00, receive_error_count_q}; // see R4
			end else if (mgmt_addr == `PHYEC_OFS_CODING_CFG) begin
				rdata_q <= cfg_q;
			end else begin
				rdata_q <= 16'h0000;
			end
		end
	end

	// An event in the read cycle is kept as the first count after the clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			false_carrier_count_q <= 8'h00; // see R3
		end else if (clk_en) begin
			if (rd_fc) begin
				false_carrier_count_q <= {7'h00, false_carrier_event}; // see R3
			end else if (false_carrier_event && false_carrier_count_q != `PHYEC_CNT_MAX) begin
				false_carrier_count_q <= false_carrier_count_q + 8'h01; // see R1 see R2
			end
		end
	end

	// Carrier tracking: error and collision seen anywhere in the carrier
	assign carrier_end = carrier_q && !rx_carrier;
	assign re_inc = carrier_end && err_seen_q && !coll_seen_q; // see R5 see R6 see R7

	always_ff @(posedge clk) begin
		if (!resetn) begin
			carrier_q <= 1'b0;
			err_seen_q <= 1'b0;
			coll_seen_q <= 1'b0;
		end else if (clk_en) begin
			carrier_q <= rx_carrier;
			if (rx_carrier) begin
				err_seen_q <= err_seen_q || rx_symbol_error;
				coll_seen_q <= coll_seen_q || rx_collision;
			end else begin
				err_seen_q <= 1'b0;
				coll_seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			receive_error_count_q <= 8'h00; // see R3
		end else if (clk_en) begin
			if (rd_re) begin
				receive_error_count_q <= {7'h00, re_inc}; // see R3
			end else if (re_inc && receive_error_count_q != `PHYEC_CNT_MAX) begin
				receive_error_count_q <= receive_error_count_q + 8'h01; // see R5 see R8
			end
		end
	end

	// Half-full pulses on the MSB rise only, so a stuck count cannot re-fire
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fc_hf_q <= 1'b0;
			re_hf_q <= 1'b0;
		end else if (clk_en) begin
			fc_hf_q <= !false_carrier_count_q[`PHYEC_CNT_MSB] && !rd_fc && false_carrier_event
				&& (false_carrier_count_q == `PHYEC_CNT_HALF); // see R19
			re_hf_q <= !receive_error_count_q[`PHYEC_CNT_MSB] && !rd_re && re_inc
				&& (receive_error_count_q == `PHYEC_CNT_HALF); // see R19
		end else begin
			fc_hf_q <= 1'b0;
			re_hf_q <= 1'b0;
		end
	end

	// Long timeout lets jumbo frames pass without losing descrambler sync
	assign timeout_limit = cfg_q[`PHYEC_BIT_DESCRAMBLER_TIMEOUT_SELECT] ? phyec_timer_t'(DESC_LONG_CYCLES)
		: phyec_timer_t'(DESC_SHORT_CYCLES); // see R13

	always_ff @(posedge clk) begin
		if (!resetn) begin
			timer_q <= 17'h00000;
			lock_q <= 1'b0;
		end else if (clk_en) begin
			if (descrambler_sync) begin
				timer_q <= 17'h00000;
				lock_q <= 1'b1;
			end else if (timer_q >= timeout_limit - 17'h00001) begin
				lock_q <= 1'b0; // see R13
			end else begin
				timer_q <= timer_q + 17'h00001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			link_q <= PHYEC_LINK_DOWN;
		end else if (clk_en) begin
			case (link_q)
				PHYEC_LINK_DOWN: begin
					if (signal_detect && lock_q) begin
						link_q <= PHYEC_LINK_UP; // see R11 see R12
					end
				end
				PHYEC_LINK_UP: begin
					if (!signal_detect) begin
						link_q <= PHYEC_LINK_DOWN; // see R11
					end else if (!signal_detect_option && !lock_q) begin
						link_q <= PHYEC_LINK_DOWN; // see R12
					end
				end
				default: begin
					link_q <= PHYEC_LINK_DOWN;
				end
			endcase
		end
	end

	AST_FC_INC: assert property (@(posedge clk) disable iff (!resetn) // see R1
		clk_en && false_carrier_event && !rd_fc && false_carrier_count_q != 8'hff
		|=> false_carrier_count_q == $past(false_carrier_count_q) + 8'h01)
		else $error("false carrier count did not step");

	AST_FC_SAT: assert property (@(posedge clk) disable iff (!resetn) // see R2
		clk_en && !rd_fc && false_carrier_count_q == 8'hff |=> false_carrier_count_q == 8'hff)
		else $error("false carrier count wrapped");

	AST_COR: assert property (@(posedge clk) disable iff (!resetn) // see R3
		clk_en && rd_fc && !false_carrier_event
		|=> false_carrier_count_q == 8'h00 && rdata_q == {8'h00, $past(false_carrier_count_q)})
		else $error("read did not return and clear false carrier count");

	AST_RSVD: assert property (@(posedge clk) disable iff (!resetn) // see R4
		clk_en && mgmt_rd && mgmt_addr != `PHYEC_OFS_CODING_CFG |=> rdata_q[15:8] == 8'h00)
		else $error("reserved bits read nonzero");

	AST_RE_ONCE: assert property (@(posedge clk) disable iff (!resetn) // see R6
		clk_en && !rd_re && rx_carrier |=> $stable(receive_error_count_q))
		else $error("receive error count moved during carrier");

	AST_RE_COLL: assert property (@(posedge clk) disable iff (!resetn) // see R7
		clk_en && !rd_re && carrier_end && coll_seen_q |=> $stable(receive_error_count_q))
		else $error("receive error counted despite collision");

	AST_RE_INC: assert property (@(posedge clk) disable iff (!resetn) // see R5
		clk_en && !rd_re && carrier_end && err_seen_q && !coll_seen_q
		&& receive_error_count_q != 8'hff
		|=> receive_error_count_q == $past(receive_error_count_q) + 8'h01)
		else $error("receive error not counted");

	AST_RE_SAT: assert property (@(posedge clk) disable iff (!resetn) // see R8
		clk_en && !rd_re && receive_error_count_q == 8'hff |=> receive_error_count_q == 8'hff)
		else $error("receive error count wrapped");

	AST_FORCE_LINK: assert property (@(posedge clk) disable iff (!resetn) // see R14
		cfg_q[`PHYEC_BIT_FORCE_100_OK] |-> link_100_ok)
		else $error("forced link not reported");

	AST_SD_FORCE: assert property (@(posedge clk) disable iff (!resetn) // see R10
		cfg_q[`PHYEC_BIT_SD_FORCE] |-> signal_detect)
		else $error("signal detect not forced");

	AST_LINK_DROP: assert property (@(posedge clk) disable iff (!resetn) // see R12
		clk_en && link_q == PHYEC_LINK_UP && !signal_detect_option && !lock_q
		|=> link_q == PHYEC_LINK_DOWN)
		else $error("link held after lock loss");

	AST_RESET_CFG: assert property (@(posedge clk) // see R17
		!resetn |=> cfg_q == 16'h0100 && false_carrier_count_q == 8'h00)
		else $error("wrong reset state");

	AST_HALF: assert property (@(posedge clk) disable iff (!resetn) // see R19
		clk_en && !rd_fc && false_carrier_event && false_carrier_count_q == 8'h7f
		|=> fc_hf_q ##1 !fc_hf_q)
		else $error("half-full event not single pulse");

	AST_RE_HALF: assert property (@(posedge clk) disable iff (!resetn) // see R19
		clk_en && !rd_re && re_inc && receive_error_count_q == 8'h7f
		|=> re_hf_q ##1 !re_hf_q)
		else $error("receive half-full event not single pulse");

	AST_FC_HF_ONLY: assert property (@(posedge clk) disable iff (!resetn) // see R19
		fc_hf_q |-> false_carrier_count_q == 8'h80)
		else $error("false carrier half-full event off the midpoint");

	AST_RE_HF_ONLY: assert property (@(posedge clk) disable iff (!resetn) // see R19
		re_hf_q |-> receive_error_count_q == 8'h80)
		else $error("receive half-full event off the midpoint");

	AST_WR_CNT: assert property (@(posedge clk) disable iff (!resetn) // see R3
		clk_en && mgmt_wr && !mgmt_rd && mgmt_addr == `PHYEC_OFS_FALSE_CARRIER
		&& !false_carrier_event |=> $stable(false_carrier_count_q))
		else $error("write altered false carrier count");

	AST_CFG_RSVD: assert property (@(posedge clk) disable iff (!resetn) // see R4
		clk_en && mgmt_rd && mgmt_addr == `PHYEC_OFS_CODING_CFG
		|=> (rdata_q & ~`PHYEC_CFG_WR_MASK) == 16'h0000)
		else $error("reserved config bits read nonzero");

	AST_TQ_WR: assert property (@(posedge clk) disable iff (!resetn) // see R9
		clk_en && wr_cfg
		|=> true_quiet_enable == $past(mgmt_wdata[`PHYEC_BIT_TRUE_QUIET]))
		else $error("true quiet enable not written");

	AST_NRZI_WR: assert property (@(posedge clk) disable iff (!resetn) // see R15
		clk_en && wr_cfg
		|=> nrzi_bypass == $past(mgmt_wdata[`PHYEC_BIT_NRZI_BYPASS]))
		else $error("nrzi bypass not written");

	AST_SD_FOLLOW: assert property (@(posedge clk) disable iff (!resetn) // see R10
		!signal_detect_force |-> signal_detect == signal_level_valid)
		else $error("signal detect not following signal level");

	AST_LINK_UP: assert property (@(posedge clk) disable iff (!resetn) // see R11
		clk_en && link_q == PHYEC_LINK_DOWN && signal_detect && lock_q
		|=> link_q == PHYEC_LINK_UP)
		else $error("link not raised on signal and lock");

	AST_LINK_KEEP: assert property (@(posedge clk) disable iff (!resetn) // see R11
		clk_en && link_q == PHYEC_LINK_UP && signal_detect && signal_detect_option
		|=> link_q == PHYEC_LINK_UP)
		else $error("link dropped with signal valid and option set");

	AST_SIG_DROP: assert property (@(posedge clk) disable iff (!resetn) // see R12
		clk_en && link_q == PHYEC_LINK_UP && !signal_detect
		|=> link_q == PHYEC_LINK_DOWN)
		else $error("link held after signal loss");

	AST_LOCK_SET: assert property (@(posedge clk) disable iff (!resetn) // see R13
		clk_en && descrambler_sync |=> descrambler_locked)
		else $error("descrambler lock not set on sync");

	AST_LOCK_TIMEOUT: assert property (@(posedge clk) disable iff (!resetn) // see R13
		clk_en && !descrambler_sync && timer_q == timeout_limit - 17'h00001
		|=> !descrambler_locked)
		else $error("descrambler lock outlived its timeout");

	AST_FREEZE: assert property (@(posedge clk) disable iff (!resetn) // see R1
		!clk_en |=> $stable(false_carrier_count_q) && $stable(receive_error_count_q)
		&& $stable(cfg_q) && $stable(link_q))
		else $error("state moved while clock enable low");

	AST_RESET_ALL: assert property (@(posedge clk) // see R3
		!resetn |=> receive_error_count_q == 8'h00 && !lock_q && !fc_hf_q && !re_hf_q
		&& link_q == PHYEC_LINK_DOWN && rdata_q == 16'h0000)
		else $error("wrong reset state of counters and link");

	COV_FC_SAT: cover property (@(posedge clk) false_carrier_count_q == 8'hff);
	COV_RE_INC: cover property (@(posedge clk) re_inc && !rd_re);
	COV_LINK_UP: cover property (@(posedge clk) link_q == PHYEC_LINK_UP);
	COV_LOCK_LOST: cover property (@(posedge clk) $fell(lock_q));
	COV_RE_HALF: cover property (@(posedge clk) re_hf_q);
endmodule

// ---- phyec_mgr_model.sv ----
// Station manager model driving the register strobe port
`timescale 1ns/1ps
module phyec_mgr_model (
	input wire logic clk,
	output logic [4:0] mgmt_addr,
	output logic mgmt_rd,
	output logic mgmt_wr,
	output logic [15:0] mgmt_wdata
);
	initial begin
		mgmt_addr = 5'h00;
		mgmt_rd = 1'b0;
		mgmt_wr = 1'b0;
		mgmt_wdata = 16'h0000;
	end

	// One access, strobe held for exactly one taken edge
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		mgmt_addr <= a;
		mgmt_rd <= !w;
		mgmt_wr <= w;
		mgmt_wdata <= d & ~16'h105b;
		@(posedge clk);
		mgmt_rd <= 1'b0;
		mgmt_wr <= 1'b0;
		// Released lines scrambled so stale values are never trusted
		mgmt_addr <= ~a;
		mgmt_wdata <= ~d;
	endtask
endmodule

// ---- phy_error_counters_pcs_config_tb_top.sv ----
// Self-checking bench for the error counters and PCS configuration
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, s); end end
module phy_error_counters_pcs_config_tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] mgmt_addr;
	logic mgmt_rd, mgmt_wr;
	logic [15:0] mgmt_wdata, mgmt_rdata;
	logic fc_ev = 0, carrier = 0, sym_err = 0, coll = 0, sig_ok = 0, sync = 0;
	logic sd, lock, link, tq, nrzi, fclk, fhf, rhf;
	logic [15:0] q[$];
	logic [15:0] exp_v, d;
	logic rd_q = 0;
	logic ce = 1'b1;
	int n_errors = 0, compares = 0, n_fhf = 0, n_rhf = 0;

	always #10 clk = ~clk;

	phyec_mgr_model u_mgr (.clk(clk), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
		.mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata));

	phyec_regs #(.DESC_SHORT_CYCLES(20), .DESC_LONG_CYCLES(50)) dut (.clk(clk),
		.resetn(resetn), .clk_en(ce), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
		.mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.false_carrier_event(fc_ev), .rx_carrier(carrier), .rx_symbol_error(sym_err),
		.rx_collision(coll), .signal_level_valid(sig_ok), .descrambler_sync(sync),
		.signal_detect(sd), .descrambler_locked(lock), .link_100_ok(link),
		.true_quiet_enable(tq), .nrzi_bypass(nrzi), .free_rx_clock(fclk),
		.false_carrier_half_full_event(fhf), .receive_error_half_full_event(rhf));

	// Read data compared one edge after the taken strobe
	always @(posedge clk) begin
		if (rd_q) begin
			exp_v = q.pop_front();
			`CHK("mgmt_rdata", exp_v, mgmt_rdata)
		end
		rd_q <= mgmt_rd;
		if (fhf === 1'b1) n_fhf++;
		if (rhf === 1'b1) n_rhf++;
	end

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		q.push_back(e);
		u_mgr.acc(1'b0, a, 16'h0000);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		u_mgr.acc(1'b1, a, v);
	endtask

	task automatic fc_burst(input int n);
		repeat (n) begin
			@(posedge clk) fc_ev <= 1'b1;
			@(posedge clk) fc_ev <= 1'b0;
		end
	endtask

	// Carrier of two cycles, error and collision held throughout
	task automatic car(input logic e, input logic c);
		@(posedge clk);
		carrier <= 1'b1;
		sym_err <= e;
		coll <= c;
		repeat (2) @(posedge clk);
		carrier <= 1'b0;
		sym_err <= 1'b0;
		coll <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pulse_sync;
		@(posedge clk) sync <= 1'b1;
		@(posedge clk) sync <= 1'b0;
	endtask

	task automatic final_report;
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the whole sequence
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		final_report();
	end

	initial begin
		void'($urandom(21));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd(`PHYEC_OFS_CODING_CFG, `PHYEC_CFG_RESET);
		rd(`PHYEC_OFS_FALSE_CARRIER, 16'h0000);
		rd(`PHYEC_OFS_RX_ERROR, 16'h0000);
		rd(5'h1f, 16'h0000);
		d = 16'($urandom()) | 16'he000;
		wr(`PHYEC_OFS_CODING_CFG, d);
		rd(`PHYEC_OFS_CODING_CFG, d & 16'h0fa4);
		`CHK("true_quiet_enable", d[10], tq)
		`CHK("nrzi_bypass", d[2], nrzi)
		`CHK("free_rx_clock", d[11], fclk)
		wr(`PHYEC_OFS_CODING_CFG, 16'h0220);
		@(posedge clk);
		`CHK("signal_detect", 1'b1, sd)
		`CHK("link_100_ok", 1'b1, link)
		fc_burst(5);
		wr(`PHYEC_OFS_FALSE_CARRIER, 16'hffff);
		rd(`PHYEC_OFS_FALSE_CARRIER, 16'h0005);
		fc_burst(300);
		rd(`PHYEC_OFS_FALSE_CARRIER, 16'h00ff);
		rd(`PHYEC_OFS_FALSE_CARRIER, 16'h0000);
		`CHK("fc_half_full", 1, n_fhf)
		car(1'b1, 1'b1);
		car(1'b0, 1'b0);
		car(1'b1, 1'b0);
		car(1'b1, 1'b0);
		rd(`PHYEC_OFS_RX_ERROR, 16'h0002);
		repeat (300) car(1'b1, 1'b0);
		rd(`PHYEC_OFS_RX_ERROR, 16'h00ff);
		`CHK("rx_half_full", 1, n_rhf)
		// Long timeout with default link option
		wr(`PHYEC_OFS_CODING_CFG, 16'h0180);
		sig_ok <= 1'b1;
		pulse_sync();
		repeat (30) @(posedge clk);
		`CHK("locked_long", 1'b1, lock)
		`CHK("link_up", 1'b1, link)
		repeat (30) @(posedge clk);
		`CHK("lock_lost", 1'b0, lock)
		`CHK("link_kept", 1'b1, link)
		wr(`PHYEC_OFS_CODING_CFG, 16'h0000);
		repeat (3) @(posedge clk);
		`CHK("link_dropped", 1'b0, link)
		pulse_sync();
		repeat (10) @(posedge clk);
		`CHK("locked_short", 1'b1, lock)
		repeat (20) @(posedge clk);
		`CHK("lock_short_lost", 1'b0, lock)
		pulse_sync();
		repeat (2) @(posedge clk);
		`CHK("link_relocked", 1'b1, link)
		sig_ok <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("link_signal_lost", 1'b0, link)
		`CHK("signal_detect_low", 1'b0, sd)
		// Frozen block must ignore events and writes
		ce <= 1'b0;
		fc_burst(3);
		wr(`PHYEC_OFS_CODING_CFG, 16'h0fa4);
		ce <= 1'b1;
		rd(`PHYEC_OFS_CODING_CFG, 16'h0000);
		rd(`PHYEC_OFS_FALSE_CARRIER, 16'h0000);
		repeat (4) @(posedge clk);
		`CHK("queue_empty", 0, q.size())
		final_report();
	end
endmodule
